// File: inc/acsc_pkg.sv
// constants shared by the eight-channel converter serial control block
package acsc_pkg;
  localparam int ACSC_RES_W = 8;            // result width in bits
  localparam int ACSC_CHAN_W = 3;           // channel address width
  localparam int ACSC_CTRL_W = 8;           // control word width
  localparam int ACSC_CONV_EDGES = 16;      // serial clock cycles per conversion
  localparam int ACSC_CTRL_EDGES = 8;       // rising edges carrying the control word
  localparam int ACSC_TRACK_CYC = 3;        // cycles spent tracking
  localparam int ACSC_LEAD_ZEROS = 4;       // falling edges of leading zeros
  localparam int ACSC_CHAN_MSB = 5;         // channel field top bit in control word
  localparam int ACSC_CHAN_LSB = 3;         // channel field bottom bit
  localparam logic [2:0] ACSC_CHAN_RST = 3'h0; // default channel after reset
  localparam logic [7:0] ACSC_CODE_MAX = 8'hFF; // full scale code
  localparam logic [4:0] ACSC_CNT_RST = 5'h00;  // edge counter reset value
endpackage : acsc_pkg

// File: hw/acsc_fifo.sv
// small valid/ready FIFO carrying converter results
`timescale 1ns/100ps
module acsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
    $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW:0] wr_ptr;            // write pointer with wrap bit
  logic [AW:0] rd_ptr;            // read pointer with wrap bit
  logic do_wr;
  logic do_rd;
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;
  assign in_ready_o = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  // write side
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
    end else if (do_wr) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end
  // storage has no reset, it is only read when valid
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  // read side
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr <= '0;
    end else if (do_rd) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : acsc_fifo

// File: hw/acsc_serial_ctrl.sv
// serial control logic of an eight-input 8-bit converter
`timescale 1ns/100ps
module acsc_serial_ctrl
  import acsc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic frame_sel_b_i,      // active-low frame select pin
  input wire logic sclk_i,             // serial clock pin
  input wire logic cmd_in_i,           // serial command input pin
  output logic res_out_o,              // serial result output level
  output logic res_out_oe_b_o,         // low while the result pin is driven
  input wire logic [7:0] sample_code_i, // digitized input from the analog core
  output logic [2:0] chan_sel_o,       // input multiplexer address
  output logic track_o,                // high while sampling input
  output logic powered_o,              // high while core is powered
  output logic [7:0] res_data_o,       // completed result stream
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic overflow_o              // result lost because FIFO full
);
  if (FIFO_DEPTH < 2) begin : g_depth_bad
    $error("fifo depth too small");
  end
  // pin synchronisers
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] din_sync;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      din_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[0], frame_sel_b_i};
      sck_sync <= {sck_sync[0], sclk_i};
      din_sync <= {din_sync[0], cmd_in_i};
    end
  end
  // delayed copies for edge finding; only second stages are read
  // the clock copy resets low though the pin idles high; the frame gate hides that
  // false rise, since no frame can be open so soon after reset
  logic sck_q;
  logic cs_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sck_q <= sck_sync[1];
      cs_q <= cs_sync[1];
    end
  end
  logic in_frame;
  logic frame_start;
  logic sck_rise;
  logic sck_fall;
  assign in_frame = !cs_sync[1];
  assign frame_start = cs_q && !cs_sync[1];
  // clock gated off outside frame
  assign sck_rise = in_frame && !sck_q && sck_sync[1];
  // frame falling with clock low counts as the first falling edge
  assign sck_fall = in_frame && ((sck_q && !sck_sync[1]) || (frame_start && !sck_sync[1]));
  // counters within a 16-cycle conversion
  logic [4:0] rise_cnt;  // rising edges seen in this conversion
  logic [4:0] fall_cnt;  // falling edges seen in this conversion
  logic [4:0] next_fall;
  always_comb begin
    next_fall = (fall_cnt == 5'(ACSC_CONV_EDGES)) ? 5'h01 : fall_cnt + 5'h01;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_cnt <= ACSC_CNT_RST;
      fall_cnt <= ACSC_CNT_RST;
    end else if (!in_frame) begin
      rise_cnt <= ACSC_CNT_RST;
      fall_cnt <= ACSC_CNT_RST;
    end else begin
      if (sck_rise) begin
        rise_cnt <= (rise_cnt == 5'(ACSC_CONV_EDGES)) ? 5'h01 : rise_cnt + 5'h01;
      end
      if (sck_fall) begin
        fall_cnt <= next_fall;
      end
    end
  end
  // control word shift register, msb first; every conversion carries its own word,
  // so a host that repeats one word keeps the channel fixed
  logic [7:0] ctrl_shift;
  logic ctrl_phase;  // high on the rises that carry control bits
  // the counter reads 0 at frame start and 16 at a conversion boundary: both mean rise 1
  assign ctrl_phase = (rise_cnt < 5'(ACSC_CTRL_EDGES)) || (rise_cnt == 5'(ACSC_CONV_EDGES));
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_shift <= 8'h00;
    end else if (sck_rise && ctrl_phase) begin
      // bits after the 8th rise never reach the shifter
      ctrl_shift <= {ctrl_shift[6:0], din_sync[1]};
    end
  end
  // channel register; new address applies to the next conversion
  logic [2:0] chan_pending;
  logic chan_load;
  // the 8th rise completes the word; before that shift the field sits in bits 4..2
  // a frame cut before the 8th rise keeps the old channel, a half word never loads
  assign chan_load = sck_rise && (rise_cnt == 5'(ACSC_CTRL_EDGES - 1));
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_pending <= ACSC_CHAN_RST;
      chan_sel_o <= ACSC_CHAN_RST;
    end else begin
      if (chan_load) begin
        // only bits 5..3 kept, the rest never reach any logic
        chan_pending <= {ctrl_shift[ACSC_CHAN_MSB-1:ACSC_CHAN_LSB-1]};
      end
      if (sck_fall && next_fall == 5'h01) begin
        chan_sel_o <= chan_pending;
      end
    end
  end
  // track, power and sample capture
  // power follows frame select but drops between back-to-back conversions to save energy
  logic [7:0] result;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      track_o <= 1'b0;
      powered_o <= 1'b0;
      result <= 8'h00;
    end else begin
      if (!in_frame) begin
        powered_o <= 1'b0;
        track_o <= 1'b0;
      end else if (sck_fall && next_fall == 5'h01) begin
        powered_o <= 1'b1;
        track_o <= 1'b1;
      end else if (sck_fall && next_fall == 5'(ACSC_CONV_EDGES)) begin
        powered_o <= 1'b0;
      end else if (frame_start) begin
        powered_o <= 1'b1;
      end
      if (sck_fall && next_fall == 5'(ACSC_LEAD_ZEROS)) begin
        track_o <= 1'b0;
        result <= sample_code_i;
      end
    end
  end
  // serial output: zeros, result msb first, zeros
  // bit_idx indexes the held result, 0 for its msb
  logic [4:0] bit_idx;
  always_comb begin
    bit_idx = next_fall - 5'(ACSC_LEAD_ZEROS + 1);
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_out_o <= 1'b0;
      res_out_oe_b_o <= 1'b1;
    end else begin
      res_out_oe_b_o <= !in_frame;
      if (!in_frame) begin
        res_out_o <= 1'b0;
      end else if (sck_fall) begin
        if (next_fall > 5'(ACSC_LEAD_ZEROS) && next_fall <= 5'(ACSC_LEAD_ZEROS + ACSC_RES_W)) begin
          // the held code, not the live core input, so all 8 bits belong together
          res_out_o <= result[3'(7 - bit_idx)];
        end else begin
          res_out_o <= 1'b0;
        end
      end
    end
  end
  // completed results go into the buffer on the fall that sends the last result bit
  // a full buffer drops the newest result and keeps the older ones
  logic push;
  logic fifo_ready;
  logic [7:0] fifo_data;
  logic fifo_valid;
  assign push = sck_fall && next_fall == 5'(ACSC_LEAD_ZEROS + ACSC_RES_W);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= push && !fifo_ready; // pulse when a result is dropped
    end
  end
  acsc_fifo #(.WIDTH(ACSC_RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_data_i(result),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(res_ready_i || !res_valid_o)
  );
  // output stage register so outputs come from flip-flops
  // the stage loads whenever it is empty or its word is being taken
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_valid_o <= 1'b0;
      res_data_o <= 8'h00;
    end else if (res_ready_i || !res_valid_o) begin
      res_valid_o <= fifo_valid;
      res_data_o <= fifo_data;
    end
  end
endmodule : acsc_serial_ctrl

// File: dv/acsc_host_model.sv
// host serial master model: frame select, serial clock and command line
`timescale 1ns/100ps
module acsc_host_model (
  input wire logic clk_i,
  input wire logic res_out_i,
  output logic frame_sel_b_o,
  output logic sclk_o,
  output logic cmd_o
);
  // idle: frame off, serial clock parked high, it never runs free
  initial begin
    frame_sel_b_o = 1'b1;
    sclk_o = 1'b1;
    cmd_o = 1'b0;
  end
  // open or close a frame; long idle spans give burst operation
  // with sck_low the clock drops first, so the frame opens with the clock already low
  task automatic frame(input logic on, input logic sck_low);
    if (on && sck_low) begin
      @(posedge clk_i) sclk_o <= 1'b0;
      @(posedge clk_i) frame_sel_b_o <= 1'b0;
    end else begin
      @(posedge clk_i) frame_sel_b_o <= !on;
      repeat (8) @(posedge clk_i);
    end
  endtask : frame
  // one conversion of 16 serial clocks at 8 system clocks each
  task automatic conv(input logic [7:0] ctrl, output logic [15:0] got);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i) sclk_o <= 1'b0;
      // msb first on the first 8 rises, a toggling pattern after that
      cmd_o <= (i < 8) ? ctrl[7-i] : !cmd_o;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      // sampled late in the period so the delayed output has settled
      got[15-i] = res_out_i;
    end
  endtask : conv
endmodule : acsc_host_model

// File: dv/acsc_serial_ctrl_sva.sv
// concurrent checks on the converter serial control ports
`timescale 1ns/100ps
module acsc_serial_ctrl_sva #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic frame_sel_b_i,
  input wire logic res_out_o,
  input wire logic res_out_oe_b_o,
  input wire logic [2:0] chan_sel_o,
  input wire logic track_o,
  input wire logic powered_o,
  input wire logic [7:0] res_data_o,
  input wire logic res_valid_o,
  input wire logic res_ready_i,
  input wire logic overflow_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // five idle cycles cover the pin synchroniser delay
  a_oe_idle_off: assert property (frame_sel_b_i [*5] |-> res_out_oe_b_o)
    else $error("result pin driven outside frame");
  a_power_idle_off: assert property (frame_sel_b_i [*5] |-> !powered_o)
    else $error("core powered outside frame");
  a_track_len: assert property ($rose(track_o) |-> ##[22:26] $fell(track_o))
    else $error("tracking not three serial clocks");
  a_track_powered: assert property (track_o |-> powered_o)
    else $error("tracking while powered down");
  a_chan_at_track: assert property ($changed(chan_sel_o) |-> ##[0:1] track_o)
    else $error("channel changed outside conversion start");
  a_power_gap: assert property ($fell(powered_o) |-> !powered_o [*6])
    else $error("power down gap too short");
  // end of tracking at fall 4, power must drop at fall 16, twelve 8-cycle periods later
  a_power_rest: assert property ($fell(track_o) |-> ##[90:100] !powered_o)
    else $error("no power down after conversion");
  a_lead_zero: assert property (track_o |-> !res_out_o)
    else $error("leading bit not zero");
  a_valid_hold: assert property (res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
    else $error("stream word changed before taken");
  a_drop_full: assert property (overflow_o |-> res_valid_o)
    else $error("drop while buffer not full");
endmodule : acsc_serial_ctrl_sva

// File: dv/testbench.sv
// top bench: host model, analog stand-in and result stream scoreboard
`timescale 1ns/100ps
module testbench;
  import acsc_pkg::*;
  logic clk_i, rst_b_i, frame_sel_b_i, sclk_i, cmd_in_i, res_out_o, res_out_oe_b_o;
  logic track_o, powered_o, res_valid_o, res_ready_i, overflow_o;
  logic [7:0] sample_code_i, res_data_o, ctrl, code;
  logic [2:0] chan_sel_o, prev_chan;
  logic [15:0] got;
  logic [31:0] seed;
  logic [7:0] exp_q[$]; // expected stream words, oldest first
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  acsc_serial_ctrl #(.FIFO_DEPTH(8)) i_acsc_serial_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .frame_sel_b_i(frame_sel_b_i), .sclk_i(sclk_i), .cmd_in_i(cmd_in_i), .res_out_o(res_out_o),
    .res_out_oe_b_o(res_out_oe_b_o), .sample_code_i(sample_code_i), .chan_sel_o(chan_sel_o),
    .track_o(track_o), .powered_o(powered_o), .res_data_o(res_data_o),
    .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .overflow_o(overflow_o));
  // the host sees the pin: a released pin shows the inverse, so a missing enable is caught
  acsc_host_model i_acsc_host_model (.clk_i(clk_i),
    .res_out_i(res_out_oe_b_o ? !res_out_o : res_out_o),
    .frame_sel_b_o(frame_sel_b_i), .sclk_o(sclk_i), .cmd_o(cmd_in_i));
  // pseudo random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // compare and count; values widened so one task serves all checks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = !clk_i;
  end
  // main sequence: frames of three back-to-back conversions each
  initial begin
    rst_b_i = 1'b0;
    res_ready_i = 1'b1;
    sample_code_i = 8'h00;
    seed = 32'h8532;
    prev_chan = 3'h0; // default channel before any write
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 36; i++) begin
      // every other frame opens with the serial clock already low
      if (i % 3 == 0) i_acsc_host_model.frame(1'b1, i % 6 == 3);
      seed = lfsr_next(seed);
      // ignored bits random, channel field walks all eight inputs
      ctrl = {seed[7:6], i[2:0], seed[2:0]};
      code = (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : seed[15:8];
      sample_code_i <= code;
      // conversions 12..23 stall the stream so the buffer overflows
      res_ready_i <= (i >= 12 && i < 24) ? 1'b0 : seed[16] | seed[17];
      exp_q.push_back(code);
      i_acsc_host_model.conv(ctrl, got);
      chk(got, {4'h0, code, 4'h0});
      chk(16'(chan_sel_o), 16'(prev_chan));
      prev_chan = i[2:0];
      if (i % 3 == 2) i_acsc_host_model.frame(1'b0, 1'b0);
    end
    res_ready_i <= 1'b1;
    for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge clk_i);
    chk(16'(exp_q.size()), 16'h0000);
    close_out();
  end
  // scoreboard: a taken word matches the oldest note; a drop loses the newest
  always @(posedge clk_i) begin
    if (rst_b_i && res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
      // a word with no note left can never match: the stand-in note is out of range
      chk(16'(res_data_o), (exp_q.size() > 0) ? 16'(exp_q.pop_front()) : 16'hFFFF);
    end
    if (rst_b_i && overflow_o === 1'b1) begin
      void'(exp_q.pop_back());
    end
  end
  // hang guard, about four times the expected run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
endmodule : testbench
bind acsc_serial_ctrl acsc_serial_ctrl_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_acsc_serial_ctrl_sva (
  .clk_i, .rst_b_i, .frame_sel_b_i, .res_out_o, .res_out_oe_b_o, .chan_sel_o, .track_o,
  .powered_o, .res_data_o, .res_valid_o, .res_ready_i, .overflow_o);
